// ==== aro_pkg.sv ====
// Shared constants and types for the resampler rate and output routing bank
package aro_pkg;

	// ==========================================================
	// Register map, as word indices; byte address is index times four
	localparam logic [15:0] ARO_RATE_FIRST_IDX = 16'hF140;
	localparam logic [15:0] ARO_RATE_LAST_IDX = 16'hF147;
	localparam logic [15:0] ARO_SRC_FIRST_IDX = 16'hF180;
	localparam logic [15:0] ARO_SRC_LAST_IDX = 16'hF197;
	localparam int ARO_RS_PAIRS = 8;
	localparam int ARO_OUT_PAIRS = 24;

	// ==========================================================
	// Field layouts and reset values
	localparam int ARO_RATE_W = 4;
	localparam int ARO_SRC_KIND_W = 3;
	localparam int ARO_RS_SEL_W = 3;
	localparam int ARO_SRC_W = ARO_SRC_KIND_W + ARO_RS_SEL_W;
	localparam logic [ARO_RATE_W-1:0] ARO_RATE_RESET = 4'h0;
	localparam logic [ARO_SRC_W-1:0] ARO_SRC_RESET = 6'h00;

	// ==========================================================
	// Target rate select codes
	localparam logic [3:0] ARO_RATE_NONE = 4'h0;
	localparam logic [3:0] ARO_RATE_SOUT0 = 4'h1;
	localparam logic [3:0] ARO_RATE_SOUT3 = 4'h4;
	localparam logic [3:0] ARO_RATE_CORE = 4'h5;
	localparam logic [3:0] ARO_RATE_GEN1_X1 = 4'h6;
	localparam logic [3:0] ARO_RATE_GEN1_X2 = 4'h7;
	localparam logic [3:0] ARO_RATE_GEN1_X4 = 4'h8;
	localparam logic [3:0] ARO_RATE_GEN1_D2 = 4'h9;
	localparam logic [3:0] ARO_RATE_GEN2_D3 = 4'hA;
	localparam logic [3:0] ARO_RATE_GEN1_D4 = 4'hB;
	localparam logic [3:0] ARO_RATE_GEN2_D6 = 4'hC;

	// Ratio factors applied to a clock generator rate
	localparam logic [2:0] ARO_F1 = 3'h1;
	localparam logic [2:0] ARO_F2 = 3'h2;
	localparam logic [2:0] ARO_F3 = 3'h3;
	localparam logic [2:0] ARO_F4 = 3'h4;
	localparam logic [2:0] ARO_F6 = 3'h6;

	// ==========================================================
	// Output pair source kinds
	localparam logic [2:0] ARO_SRC_OFF = 3'h0;
	localparam logic [2:0] ARO_SRC_SERIAL = 3'h1;
	localparam logic [2:0] ARO_SRC_CORE = 3'h2;
	localparam logic [2:0] ARO_SRC_RESAMPLER = 3'h3;
	localparam logic [2:0] ARO_SRC_MIC01 = 3'h4;
	localparam logic [2:0] ARO_SRC_MIC23 = 3'h5;

	// Output ports: first pair and pair count of each
	localparam int ARO_P0_FIRST = 0;
	localparam int ARO_P0_PAIRS = 8;
	localparam int ARO_P1_FIRST = 8;
	localparam int ARO_P1_PAIRS = 8;
	localparam int ARO_P2_FIRST = 16;
	localparam int ARO_P2_PAIRS = 4;
	localparam int ARO_P3_FIRST = 20;
	localparam int ARO_P3_PAIRS = 4;

	localparam int ARO_SAMPLE_W = 32;

	// ==========================================================
	// Types
	typedef enum logic [2:0] {
		ARO_LOCK_NONE,
		ARO_LOCK_SOUT,
		ARO_LOCK_CORE,
		ARO_LOCK_GEN1,
		ARO_LOCK_GEN2
	} aro_lock_src_t;

	typedef struct packed {
		logic locked;
		aro_lock_src_t src;
		logic [1:0] port;
		logic [2:0] mult;
		logic [2:0] div;
	} aro_rate_sel_t;

	typedef struct packed {
		logic [ARO_SAMPLE_W-1:0] left;
		logic [ARO_SAMPLE_W-1:0] right;
	} aro_pair_t;

endpackage

// ==== aro_rate_decode.sv ====
// Decoder from a target rate select code to the resampler lock choice
`timescale 1ns/1ns
module aro_rate_decode
	import aro_pkg::*;
(
	input wire logic [ARO_RATE_W-1:0] code_i,
	output aro_rate_sel_t sel_o
);

	logic [3:0] port_off;

	assign port_off = code_i - ARO_RATE_SOUT0;

	always_comb begin
		sel_o = '0;
		sel_o.src = ARO_LOCK_NONE;
		sel_o.mult = ARO_F1;
		sel_o.div = ARO_F1;
		case (code_i)
			ARO_RATE_NONE: begin
				sel_o.locked = 1'b0;
			end
			ARO_RATE_CORE: begin
				sel_o.locked = 1'b1;
				sel_o.src = ARO_LOCK_CORE;
			end
			ARO_RATE_GEN1_X1: begin
				sel_o.locked = 1'b1;
				sel_o.src = ARO_LOCK_GEN1;
			end
			ARO_RATE_GEN1_X2: begin
				sel_o.locked = 1'b1;
				sel_o.src = ARO_LOCK_GEN1;
				sel_o.mult = ARO_F2;
			end
			ARO_RATE_GEN1_X4: begin
				sel_o.locked = 1'b1;
				sel_o.src = ARO_LOCK_GEN1;
				sel_o.mult = ARO_F4;
			end
			ARO_RATE_GEN1_D2: begin
				sel_o.locked = 1'b1;
				sel_o.src = ARO_LOCK_GEN1;
				sel_o.div = ARO_F2;
			end
			ARO_RATE_GEN1_D4: begin
				sel_o.locked = 1'b1;
				sel_o.src = ARO_LOCK_GEN1;
				sel_o.div = ARO_F4;
			end
			ARO_RATE_GEN2_D3: begin
				sel_o.locked = 1'b1;
				sel_o.src = ARO_LOCK_GEN2;
				sel_o.div = ARO_F3;
			end
			ARO_RATE_GEN2_D6: begin
				sel_o.locked = 1'b1;
				sel_o.src = ARO_LOCK_GEN2;
				sel_o.div = ARO_F6;
			end
			default: begin
				// Serial output port codes, else undefined codes leave it unlocked
				if (code_i >= ARO_RATE_SOUT0 && code_i <= ARO_RATE_SOUT3) begin
					sel_o.locked = 1'b1;
					sel_o.src = ARO_LOCK_SOUT;
					sel_o.port = port_off[1:0];
				end else begin
					sel_o.locked = 1'b0;
				end
			end
		endcase
	end

endmodule

// ==== aro_top.sv ====
// Resampler target rate registers and serial output routing matrix
//
// Chosen here: the Avalon-MM slave port.
`timescale 1ns/1ns
module aro_top
	import aro_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic [17:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	input wire logic [3:0] avs_byteenable_i,
	output logic [31:0] avs_readdata_o,
	output logic avs_waitrequest_o,
	input aro_pair_t serial_in_i [ARO_OUT_PAIRS],
	input aro_pair_t core_out_i [ARO_OUT_PAIRS],
	input aro_pair_t resampler_out_i [ARO_RS_PAIRS],
	input aro_pair_t mic_i [2],
	output aro_rate_sel_t [ARO_RS_PAIRS-1:0] rate_sel_o,
	output aro_pair_t [ARO_P0_PAIRS-1:0] serial_output_port0_o,
	output aro_pair_t [ARO_P1_PAIRS-1:0] serial_output_port1_o,
	output aro_pair_t [ARO_P2_PAIRS-1:0] serial_output_port2_o,
	output aro_pair_t [ARO_P3_PAIRS-1:0] serial_output_port3_o
);

	// ==========================================================
	// Address decode
	logic [15:0] word_idx;
	logic [15:0] rate_off;
	logic [15:0] src_off;
	logic [2:0] rate_idx;
	logic [4:0] src_idx;
	logic aligned;
	logic hit_rate;
	logic hit_src;
	logic bus_req;
	logic bus_ack;
	logic wr_done;

	assign word_idx = avs_address_i[17:2];
	assign rate_off = word_idx - ARO_RATE_FIRST_IDX;
	assign src_off = word_idx - ARO_SRC_FIRST_IDX;
	assign rate_idx = rate_off[2:0];
	assign src_idx = src_off[4:0];
	assign aligned = (avs_address_i[1:0] == 2'h0);
	assign hit_rate = aligned && word_idx >= ARO_RATE_FIRST_IDX && word_idx <= ARO_RATE_LAST_IDX;
	assign hit_src = aligned && word_idx >= ARO_SRC_FIRST_IDX && word_idx <= ARO_SRC_LAST_IDX;
	assign bus_req = avs_read_i || avs_write_i;

	// ==========================================================
	// Bus handshake: one wait cycle, answer in the second
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			bus_ack <= 1'b0;
		end else begin
			bus_ack <= bus_req && !bus_ack;
		end
	end

	assign avs_waitrequest_o = bus_req && !bus_ack;
	assign wr_done = avs_write_i && bus_ack && avs_byteenable_i[0];

	// ==========================================================
	// Target rate registers
	logic [ARO_RATE_W-1:0] rate_reg [ARO_RS_PAIRS];

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			for (int i = 0; i < ARO_RS_PAIRS; i++) begin
				rate_reg[i] <= ARO_RATE_RESET;
			end
		end else if (wr_done && hit_rate) begin
			rate_reg[rate_idx] <= avs_writedata_i[ARO_RATE_W-1:0];
		end
	end

	// ==========================================================
	// Output source registers
	logic [ARO_SRC_W-1:0] src_reg [ARO_OUT_PAIRS];

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			for (int i = 0; i < ARO_OUT_PAIRS; i++) begin
				src_reg[i] <= ARO_SRC_RESET;
			end
		end else if (wr_done && hit_src) begin
			src_reg[src_idx] <= avs_writedata_i[ARO_SRC_W-1:0];
		end
	end

	// ==========================================================
	// Read data, loaded in the wait cycle so it stands with the answer
	logic [31:0] next_readdata;

	always_comb begin
		next_readdata = 32'h0000_0000;
		if (hit_rate) begin
			next_readdata = 32'(rate_reg[rate_idx]);
		end else if (hit_src) begin
			next_readdata = 32'(src_reg[src_idx]);
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			avs_readdata_o <= 32'h0000_0000;
		end else if (avs_read_i && !bus_ack) begin
			avs_readdata_o <= next_readdata;
		end
	end

	// ==========================================================
	// Rate lock choice handed to each resampler
	aro_rate_sel_t next_rate_sel [ARO_RS_PAIRS];

	for (genvar g = 0; g < ARO_RS_PAIRS; g++) begin : g_rate
		aro_rate_decode u_dec (
			.code_i(rate_reg[g]),
			.sel_o(next_rate_sel[g])
		);
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rate_sel_o <= '0;
		end else begin
			for (int i = 0; i < ARO_RS_PAIRS; i++) begin
				rate_sel_o[i] <= next_rate_sel[i];
			end
		end
	end

	// ==========================================================
	// Output routing matrix
	aro_pair_t next_out [ARO_OUT_PAIRS];
	aro_pair_t out_pairs [ARO_OUT_PAIRS];

	for (genvar g = 0; g < ARO_OUT_PAIRS; g++) begin : g_route
		always_comb begin
			case (src_reg[g][ARO_SRC_KIND_W-1:0])
				ARO_SRC_SERIAL: begin
					next_out[g] = serial_in_i[g];
				end
				ARO_SRC_CORE: begin
					next_out[g] = core_out_i[g];
				end
				ARO_SRC_RESAMPLER: begin
					next_out[g] = resampler_out_i[src_reg[g][ARO_SRC_W-1:ARO_SRC_KIND_W]];
				end
				ARO_SRC_MIC01: begin
					next_out[g] = mic_i[0];
				end
				ARO_SRC_MIC23: begin
					next_out[g] = mic_i[1];
				end
				default: begin
					next_out[g] = '0;
				end
			endcase
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			for (int i = 0; i < ARO_OUT_PAIRS; i++) begin
				out_pairs[i] <= '0;
			end
		end else begin
			for (int i = 0; i < ARO_OUT_PAIRS; i++) begin
				out_pairs[i] <= next_out[i];
			end
		end
	end

	// Pairs split over the four ports
	for (genvar g = 0; g < ARO_P0_PAIRS; g++) begin : g_p0
		assign serial_output_port0_o[g] = out_pairs[ARO_P0_FIRST + g];
	end
	for (genvar g = 0; g < ARO_P1_PAIRS; g++) begin : g_p1
		assign serial_output_port1_o[g] = out_pairs[ARO_P1_FIRST + g];
	end
	for (genvar g = 0; g < ARO_P2_PAIRS; g++) begin : g_p2
		assign serial_output_port2_o[g] = out_pairs[ARO_P2_FIRST + g];
	end
	for (genvar g = 0; g < ARO_P3_PAIRS; g++) begin : g_p3
		assign serial_output_port3_o[g] = out_pairs[ARO_P3_FIRST + g];
	end

	// ==========================================================
	// Checks
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);

	aro_pair_t rs_pick3;
	logic [2:0] rate0_port;
	assign rs_pick3 = resampler_out_i[src_reg[3][ARO_SRC_W-1:ARO_SRC_KIND_W]];
	assign rate0_port = 3'(rate_reg[0] - ARO_RATE_SOUT0);

	a_bus_one_wait: assert property ( // handshake
		(bus_req && !bus_ack) |-> avs_waitrequest_o ##1 (!avs_waitrequest_o || !bus_req)
	) else $error("waitrequest not released after one cycle");

	a_rate_write_lands: assert property (
		(wr_done && hit_rate) |=> rate_reg[$past(rate_idx)] == $past(avs_writedata_i[3:0])
	) else $error("rate register write lost");

	a_rate_reserved_zero: assert property (
		(avs_read_i && bus_ack && hit_rate) |-> avs_readdata_o[31:ARO_RATE_W] == 28'h000_0000
	) else $error("reserved rate bits not zero");

	a_rate_none_unlocked: assert property (
		(rate_reg[0] == ARO_RATE_NONE || rate_reg[0] > ARO_RATE_GEN2_D6)
			|=> !rate_sel_o[0].locked
	) else $error("unlocked code produced a lock");

	a_rate_sout_port: assert property (
		(rate_reg[0] >= ARO_RATE_SOUT0 && rate_reg[0] <= ARO_RATE_SOUT3)
			|=> rate_sel_o[0].locked && rate_sel_o[0].src == ARO_LOCK_SOUT
			&& rate_sel_o[0].port == $past(rate0_port[1:0])
	) else $error("wrong serial port lock");

	a_rate_core_lock: assert property (
		(rate_reg[0] == ARO_RATE_CORE) |=> rate_sel_o[0].src == ARO_LOCK_CORE
	) else $error("core rate not selected");

	a_rate_gen1_mult: assert property (
		(rate_reg[0] == ARO_RATE_GEN1_X4) |=> rate_sel_o[0].src == ARO_LOCK_GEN1
			&& rate_sel_o[0].mult == ARO_F4 && rate_sel_o[0].div == ARO_F1
	) else $error("generator one times four wrong");

	a_rate_gen1_div: assert property (
		(rate_reg[0] == ARO_RATE_GEN1_D4) |=> rate_sel_o[0].src == ARO_LOCK_GEN1
			&& rate_sel_o[0].div == ARO_F4 && rate_sel_o[0].mult == ARO_F1
	) else $error("generator one quarter wrong");

	a_rate_gen2_div: assert property (
		(rate_reg[0] == ARO_RATE_GEN2_D6) |=> rate_sel_o[0].src == ARO_LOCK_GEN2
			&& rate_sel_o[0].div == ARO_F6
	) else $error("generator two sixth wrong");

	a_src_write_read: assert property (
		(wr_done && hit_src) ##2 (avs_read_i && !bus_ack && hit_src && src_idx == $past(src_idx, 2))
			##1 bus_ack |-> avs_readdata_o[5:0] == $past(avs_writedata_i[5:0], 3)
	) else $error("source register readback wrong");

	a_port_map: assert property (
		serial_output_port1_o[0] == out_pairs[ARO_P1_FIRST]
			&& serial_output_port3_o[3] == out_pairs[ARO_OUT_PAIRS - 1]
	) else $error("port mapping wrong");

	a_route_serial: assert property (
		(src_reg[1][2:0] == ARO_SRC_SERIAL) |=> out_pairs[1] == $past(serial_in_i[1])
	) else $error("serial input not routed");

	a_route_resampler: assert property (
		(src_reg[3][2:0] == ARO_SRC_RESAMPLER) |=> out_pairs[3] == $past(rs_pick3)
	) else $error("resampler pair not routed");

	// Remaining rate codes and further pairs
	a_rate_gen1_x1: assert property (
		(rate_reg[0] == ARO_RATE_GEN1_X1) |=> rate_sel_o[0].src == ARO_LOCK_GEN1
			&& rate_sel_o[0].mult == ARO_F1 && rate_sel_o[0].div == ARO_F1
	) else $error("generator one base rate wrong");

	a_rate_gen1_x2: assert property (
		(rate_reg[0] == ARO_RATE_GEN1_X2) |=> rate_sel_o[0].src == ARO_LOCK_GEN1
			&& rate_sel_o[0].mult == ARO_F2 && rate_sel_o[0].div == ARO_F1
	) else $error("generator one times two wrong");

	a_rate_gen1_half: assert property (
		(rate_reg[0] == ARO_RATE_GEN1_D2) |=> rate_sel_o[0].src == ARO_LOCK_GEN1
			&& rate_sel_o[0].div == ARO_F2 && rate_sel_o[0].mult == ARO_F1
	) else $error("generator one half wrong");

	a_rate_gen2_third: assert property (
		(rate_reg[0] == ARO_RATE_GEN2_D3) |=> rate_sel_o[0].src == ARO_LOCK_GEN2
			&& rate_sel_o[0].div == ARO_F3
	) else $error("generator two third wrong");

	a_rate_high_unlocked: assert property (
		(rate_reg[0] > ARO_RATE_GEN2_D6)
			|=> !rate_sel_o[0].locked && rate_sel_o[0].src == ARO_LOCK_NONE
	) else $error("undefined code produced a lock");

	a_rate_pair7_lock: assert property (
		(rate_reg[7] == ARO_RATE_GEN1_X2)
			|=> rate_sel_o[7].src == ARO_LOCK_GEN1 && rate_sel_o[7].mult == ARO_F2
	) else $error("last rate register not applied");

	a_rate_pair3_sout: assert property (
		(rate_reg[3] >= ARO_RATE_SOUT0 && rate_reg[3] <= ARO_RATE_SOUT3)
			|=> rate_sel_o[3].src == ARO_LOCK_SOUT
	) else $error("pair three serial lock wrong");

	a_src_reserved_zero: assert property (
		(avs_read_i && bus_ack && hit_src) |-> avs_readdata_o[31:ARO_SRC_W] == 26'h000_0000
	) else $error("reserved source bits not zero");

	a_unmapped_read_zero: assert property ( // refused access
		(avs_read_i && bus_ack && !hit_rate && !hit_src) |-> avs_readdata_o == 32'h0000_0000
	) else $error("unmapped read not zero");

	a_refused_write_kept: assert property ( // refused access
		(avs_write_i && bus_ack && !avs_byteenable_i[0]) |=> rate_reg[0] == $past(rate_reg[0])
	) else $error("disabled lane write stored");

	a_route_core: assert property (
		(src_reg[2][2:0] == ARO_SRC_CORE) |=> out_pairs[2] == $past(core_out_i[2])
	) else $error("core output not routed");

	a_route_mic01: assert property (
		(src_reg[4][2:0] == ARO_SRC_MIC01) |=> out_pairs[4] == $past(mic_i[0])
	) else $error("first microphone pair not routed");

	a_route_mic23: assert property (
		(src_reg[5][2:0] == ARO_SRC_MIC23) |=> out_pairs[5] == $past(mic_i[1])
	) else $error("second microphone pair not routed");

	a_route_off_zero: assert property (
		(src_reg[0][2:0] == ARO_SRC_OFF) |=> out_pairs[0] == '0
	) else $error("unrouted pair not silent");

	a_route_spare_zero: assert property (
		(src_reg[6][2:0] == 3'h6) |=> out_pairs[6] == '0
	) else $error("spare source kind not silent");

	a_route_port2_rs: assert property (
		(src_reg[19][2:0] == ARO_SRC_RESAMPLER)
			|=> serial_output_port2_o[3] == $past(resampler_out_i[src_reg[19][5:3]])
	) else $error("port two resampler pair wrong");

	c_rate_write: cover property (wr_done && hit_rate);
	c_src_read: cover property (avs_read_i && bus_ack && hit_src);
	c_resampler_route: cover property (src_reg[3][2:0] == ARO_SRC_RESAMPLER ##1 out_pairs[3] != '0);
	c_gen2_lock: cover property (rate_sel_o[0].src == ARO_LOCK_GEN2);
	c_mic_route: cover property (src_reg[4][2:0] == ARO_SRC_MIC01);

endmodule

// ==== aro_top_bench.sv ====
// Self-checking bench for the resampler rate and output routing bank
`timescale 1ns/1ns
module aro_top_bench;
	import aro_pkg::*;

	// ==========================================================
	// Signals
	logic clk_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic [17:0] adr = 18'h0_0000;
	logic rd = 1'b0;
	logic wr = 1'b0;
	logic [31:0] wd = 32'h0000_0000;
	logic [3:0] be = 4'hF;
	logic [31:0] rdata;
	logic wait_o;
	aro_pair_t sin [ARO_OUT_PAIRS];
	aro_pair_t cor [ARO_OUT_PAIRS];
	aro_pair_t rso [ARO_RS_PAIRS];
	aro_pair_t mic [2];
	aro_rate_sel_t [ARO_RS_PAIRS-1:0] rsel;
	aro_pair_t [ARO_P0_PAIRS-1:0] p0;
	aro_pair_t [ARO_P1_PAIRS-1:0] p1;
	aro_pair_t [ARO_P2_PAIRS-1:0] p2;
	aro_pair_t [ARO_P3_PAIRS-1:0] p3;
	int fail_count = 0;
	int cmp_count = 0;
	logic [31:0] got;
	logic [5:0] srcv [ARO_OUT_PAIRS];
	aro_pair_t old_v;

	// Rate code in, expected lock choice out, one row per code
	aro_rate_sel_t rate_tab [16] = '{
		'{0, ARO_LOCK_NONE, 0, 1, 1}, '{1, ARO_LOCK_SOUT, 0, 1, 1},
		'{1, ARO_LOCK_SOUT, 1, 1, 1}, '{1, ARO_LOCK_SOUT, 2, 1, 1},
		'{1, ARO_LOCK_SOUT, 3, 1, 1}, '{1, ARO_LOCK_CORE, 0, 1, 1},
		'{1, ARO_LOCK_GEN1, 0, 1, 1}, '{1, ARO_LOCK_GEN1, 0, 2, 1},
		'{1, ARO_LOCK_GEN1, 0, 4, 1}, '{1, ARO_LOCK_GEN1, 0, 1, 2},
		'{1, ARO_LOCK_GEN2, 0, 1, 3}, '{1, ARO_LOCK_GEN1, 0, 1, 4},
		'{1, ARO_LOCK_GEN2, 0, 1, 6}, '{0, ARO_LOCK_NONE, 0, 1, 1},
		'{0, ARO_LOCK_NONE, 0, 1, 1}, '{0, ARO_LOCK_NONE, 0, 1, 1}};

	aro_top dut (
		.clk_i(clk_i),
		.rst_n_i(rst_n_i),
		.avs_address_i(adr),
		.avs_read_i(rd),
		.avs_write_i(wr),
		.avs_writedata_i(wd),
		.avs_byteenable_i(be),
		.avs_readdata_o(rdata),
		.avs_waitrequest_o(wait_o),
		.serial_in_i(sin),
		.core_out_i(cor),
		.resampler_out_i(rso),
		.mic_i(mic),
		.rate_sel_o(rsel),
		.serial_output_port0_o(p0),
		.serial_output_port1_o(p1),
		.serial_output_port2_o(p2),
		.serial_output_port3_o(p3)
	);

	always #25 clk_i = ~clk_i;

	// ==========================================================
	// Helpers
	task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			fail_count++;
			$display("Error at %0t: saw %h, expected %h", $time, seen, exp);
		end
	endtask

	task automatic wrap_up();
		$display("Comparisons %0d, mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	// One bus transfer, held until waitrequest is seen low at a rising edge
	task automatic acc(input logic w, input logic [17:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk_i);
		adr <= a;
		wd <= d;
		wr <= w;
		rd <= !w;
		do begin
			@(posedge clk_i);
			n++;
			if (n > 20) begin
				fail_count++;
				wrap_up();
			end
		end while (wait_o !== 1'b0);
		got = rdata;
		chk(n, 2);
		wr <= 1'b0;
		rd <= 1'b0;
	endtask

	task automatic wreg(input logic [15:0] i, input logic [31:0] d);
		acc(1'b1, {i, 2'b00}, d);
	endtask

	task automatic rreg(input logic [15:0] i);
		acc(1'b0, {i, 2'b00}, 32'h0000_0000);
	endtask

	function automatic aro_pair_t pout(int k);
		if (k < 8) return p0[k];
		if (k < 16) return p1[k-8];
		if (k < 20) return p2[k-16];
		return p3[k-20];
	endfunction

	function automatic aro_pair_t src_exp(int k, logic [5:0] s);
		case (s[2:0])
			ARO_SRC_SERIAL: return sin[k];
			ARO_SRC_CORE: return cor[k];
			ARO_SRC_RESAMPLER: return rso[s[5:3]];
			ARO_SRC_MIC01: return mic[0];
			ARO_SRC_MIC23: return mic[1];
			default: return '0;
		endcase
	endfunction

	// ==========================================================
	// Main sequence
	initial begin
		for (int k = 0; k < ARO_OUT_PAIRS; k++) begin
			sin[k] = {32'h1000_0000 + k, 32'h1100_0000 + k};
			cor[k] = {32'h2000_0000 + k, 32'h2200_0000 + k};
			srcv[k] = {3'((k / 3 + 7) % 8), 3'(k % 8)};
		end
		for (int k = 0; k < ARO_RS_PAIRS; k++) begin
			rso[k] = {32'h3000_0000 + k, 32'h3300_0000 + k};
		end
		mic[0] = {32'h4000_0000, 32'h4400_0000};
		mic[1] = {32'h5000_0000, 32'h5500_0000};
		repeat (20) @(posedge clk_i);
		rst_n_i <= 1'b1;
		@(negedge clk_i);
		for (int i = 0; i < ARO_RS_PAIRS; i++) chk(rsel[i], 64'h0);
		for (int k = 0; k < ARO_OUT_PAIRS; k++) chk(pout(k), 64'h0);
		for (int i = 0; i < ARO_RS_PAIRS; i++) begin
			rreg(16'(ARO_RATE_FIRST_IDX + i));
			chk(got, 32'h0000_0000);
		end
		for (int k = 0; k < ARO_OUT_PAIRS; k++) begin
			rreg(16'(ARO_SRC_FIRST_IDX + k));
			chk(got, 32'h0000_0000);
		end
		// Every rate code into the first register and into register c mod 8, upper bits dropped
		for (int c = 0; c < 16; c++) begin
			wreg(ARO_RATE_FIRST_IDX, 32'h0000_FFF0 | c);
			wreg(16'(ARO_RATE_FIRST_IDX + c % 8), 32'h0000_FFF0 | c);
			rreg(16'(ARO_RATE_FIRST_IDX + c % 8));
			chk(got, 32'(c));
			chk(rsel[c % 8], rate_tab[c]);
			chk(rsel[0], rate_tab[c]);
		end
		// Refused writes: lane 0 disabled, unaligned, unmapped
		wreg(ARO_RATE_FIRST_IDX, 32'h0000_0008);
		be <= 4'hE;
		wreg(ARO_RATE_FIRST_IDX, 32'h0000_0005);
		be <= 4'hF;
		acc(1'b1, {ARO_RATE_FIRST_IDX, 2'b01}, 32'h0000_0005);
		wreg(16'hF148, 32'h0000_0005);
		rreg(ARO_RATE_FIRST_IDX);
		chk(got, 32'h0000_0008);
		chk(rsel[0], rate_tab[8]);
		rreg(16'hF148);
		chk(got, 32'h0000_0000);
		rreg(16'hF198);
		chk(got, 32'h0000_0000);
		// Route every output pair, all source kinds in turn
		for (int k = 0; k < ARO_OUT_PAIRS; k++) begin
			wreg(16'(ARO_SRC_FIRST_IDX + k), 32'h0000_FFC0 | srcv[k]);
			rreg(16'(ARO_SRC_FIRST_IDX + k));
			chk(got, 32'(srcv[k]));
		end
		@(negedge clk_i);
		for (int k = 0; k < ARO_OUT_PAIRS; k++) chk(pout(k), src_exp(k, srcv[k]));
		// Datapath delay is one edge
		old_v = sin[1];
		@(posedge clk_i);
		sin[1] <= {32'hABCD_0001, 32'hABCD_0002};
		@(negedge clk_i);
		chk(pout(1), old_v);
		@(negedge clk_i);
		chk(pout(1), {32'hABCD_0001, 32'hABCD_0002});
		// Reset in mid-run clears everything
		@(posedge clk_i);
		rst_n_i <= 1'b0;
		@(negedge clk_i);
		chk(rsel[0], 64'h0);
		chk(pout(1), 64'h0);
		repeat (2) @(posedge clk_i);
		rst_n_i <= 1'b1;
		rreg(16'(ARO_SRC_FIRST_IDX + 1));
		chk(got, 32'h0000_0000);
		rreg(16'(ARO_RATE_FIRST_IDX + 7));
		chk(got, 32'h0000_0000);
		wrap_up();
	end
endmodule
